// ### sdwrc_pkg.sv
// Package of constants for the development-mode, cyclic-wake and regulator sequencing block
package sdwrc_pkg;

  // ==========================================================================
  // Clock
  // ==========================================================================
  localparam int unsigned CLK_HZ = 25_000_000;

  // ==========================================================================
  // Operating modes
  // ==========================================================================
  typedef enum logic [2:0] {
    SDWRC_MODE_INIT     = 3'h0,
    SDWRC_MODE_NORMAL   = 3'h1,
    SDWRC_MODE_STOP     = 3'h2,
    SDWRC_MODE_SLEEP    = 3'h3,
    SDWRC_MODE_RESTART  = 3'h4,
    SDWRC_MODE_FAILSAFE = 3'h5
  } sdwrc_mode_type;

  // ==========================================================================
  // Periodic timer periods, milliseconds, codes 0..6; code 7 acts as 2 s
  // ==========================================================================
  localparam int unsigned PER_MS_0 = 10;
  localparam int unsigned PER_MS_1 = 20;
  localparam int unsigned PER_MS_2 = 50;
  localparam int unsigned PER_MS_3 = 100;
  localparam int unsigned PER_MS_4 = 200;
  localparam int unsigned PER_MS_5 = 1000;
  localparam int unsigned PER_MS_6 = 2000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned TMR_W = 26;

  // ==========================================================================
  // Wake source control field positions
  // ==========================================================================
  localparam int unsigned WK_TIMER_BIT = 0;
  localparam int unsigned WK_SRC_W     = 4;
  localparam logic [3:0]  WK_DEFAULT   = 4'he;

  // ==========================================================================
  // Regulator sequencing
  // ==========================================================================
  localparam int unsigned DUTY_W        = 8;
  localparam logic [7:0]  DUTY_MIN      = 8'h08;
  localparam logic [7:0]  DUTY_FULL     = 8'hff;
  localparam int unsigned SS_HOLD_DEF   = 16;
  localparam int unsigned SS_STEP_DEF   = 8;

  // Soft-start states, Gray along the path
  typedef enum logic [1:0] {
    SDWRC_SS_OFF  = 2'h0,
    SDWRC_SS_HOLD = 2'h1,
    SDWRC_SS_RAMP = 2'h3,
    SDWRC_SS_REG  = 2'h2
  } sdwrc_ss_type;

endpackage

// ### sdwrc_ramp.sv
// Soft-start duty ramp sequencer of the buck loop
`timescale 1ns/100ps
module sdwrc_ramp
  import sdwrc_pkg::*;
#(
  parameter int unsigned HOLD_PERIODS = SS_HOLD_DEF,
  parameter logic [7:0]  DUTY_STEP    = SS_STEP_DEF[7:0]
) (
  // Clock and reset
  input  wire logic              mclk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  // Control
  input  wire logic              start_i,
  input  wire logic              enable_i,
  input  wire logic              period_tick_i,
  input  wire logic              target_reached_i,
  // Status
  output logic [DUTY_W-1:0]      duty_o,
  output logic                   ramping_o,
  output logic                   regulating_o
);

  // ==========================================================================
  // State
  // ==========================================================================
  sdwrc_ss_type        state_reg, state_next;
  logic [15:0]         cnt_reg, cnt_next;
  logic [DUTY_W-1:0]   duty_reg, duty_next;

  wire hold_done = period_tick_i && (cnt_reg == 16'(HOLD_PERIODS - 1));
  wire [DUTY_W:0] duty_sum = {1'b0, duty_reg} + {1'b0, DUTY_STEP};
  wire [DUTY_W-1:0] duty_inc = duty_sum[DUTY_W] ? DUTY_FULL : duty_sum[DUTY_W-1:0];

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    state_next = state_reg;
    cnt_next   = period_tick_i ? cnt_reg + 16'h0001 : cnt_reg;
    duty_next  = duty_reg;
    unique case (state_reg)
      SDWRC_SS_OFF: begin
        cnt_next  = 16'h0000;
        duty_next = 8'h00;
      end
      SDWRC_SS_HOLD: begin
        if (hold_done) begin // [R19]
          state_next = SDWRC_SS_RAMP;
          cnt_next   = 16'h0000;
          duty_next  = duty_inc;
        end
      end
      SDWRC_SS_RAMP: begin
        if (target_reached_i) begin // [R19]
          state_next = SDWRC_SS_REG;
        end else if (hold_done) begin
          cnt_next  = 16'h0000;
          duty_next = duty_inc; // [R19]
        end
      end
      SDWRC_SS_REG: begin
        cnt_next = 16'h0000;
      end
    endcase
    if (start_i && enable_i) begin // [R18]
      state_next = SDWRC_SS_HOLD;
      cnt_next   = 16'h0000;
      duty_next  = DUTY_MIN; // [R19]
    end else if (!enable_i) begin
      state_next = SDWRC_SS_OFF;
      cnt_next   = 16'h0000;
      duty_next  = 8'h00;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_reg <= SDWRC_SS_OFF;
      cnt_reg   <= 16'h0000;
      duty_reg  <= 8'h00;
    end else if (ce_i) begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      duty_reg  <= duty_next;
    end
  end

  assign duty_o       = duty_reg;
  assign ramping_o    = (state_reg == SDWRC_SS_HOLD) || (state_reg == SDWRC_SS_RAMP);
  assign regulating_o = (state_reg == SDWRC_SS_REG);

endmodule

// ### sdwrc_ctrl.sv
// Development-mode latch, cyclic wake timer and buck regulator sequencing
//
// Behaviour
// R1: Development mode entered when strap low in init and any SPI command arrives.
// R2: After power-up the device always starts in initialisation mode.
// R3: A software reset (mode field write) blocks any later development-mode entry.
// R4: Development mode left by software reset or power-down with strap high.
// R5: In development mode no watchdog trigger needed, no watchdog reset.
// R6: Strap open or high at start-up gives normal operation, not development.
// R7: Strap pull-up enabled only in initialisation mode.
// R8: Host configures wake sources before commanding sleep.
// R9: Fail-safe mode activates all default wake sources.
// R10: Enabled periodic timer interrupts periodically in normal and stop modes.
// R11: Host writes timer period before enabling timer as wake source.
// R12: Cyclic wake starts on enable; interrupt at end of each period.
// R13: Timer periods 10, 20, 50, 100, 200 ms, 1 s, 2 s.
// R14: Regulator active in normal, stop, restart; off in sleep, fail-safe.
// R15: PWM in normal and restart; in stop only after auto or manual transition.
// R16: Entering stop mode switches buck to PFM.
// R17: PWM may reach full duty cycle on low input supply.
// R18: Soft start runs at power-up, sleep-to-restart and fail-safe-to-restart.
// R19: Soft start holds minimum duty, steps up per interval, then regulates.
// R20: Status flags switch node open, short, and output outside 12% window.
// R21: Status flags never change mode or configuration.
// R22: Host clears all wake flags before sleep or device wakes at once.
// R23: Period code 3 bits ascending from zero; code 7 acts as longest.
// R24: Soft-start hold count and step are synthesis parameters.
`timescale 1ns/100ps
module sdwrc_ctrl
  import sdwrc_pkg::*;
#(
  parameter int unsigned SS_HOLD   = SS_HOLD_DEF,
  parameter int unsigned SS_STEP   = SS_STEP_DEF,
  parameter int unsigned MS_CYCLES = CYC_PER_MS,
  parameter int unsigned SW_PERIOD = 25
) (
  // Clock, reset, enable
  input  wire logic                  mclk_i,
  input  wire logic                  rst_i,
  input  wire logic                  ce_i,
  // Mode and host commands
  input  wire sdwrc_mode_type        mode_i,
  input  wire logic                  spi_cmd_i,
  input  wire logic                  sw_reset_i,
  input  wire logic                  power_down_i,
  // Strap pin
  input  wire logic                  test_strap_pin_i,
  output logic                       strap_pullup_en_o,
  // Watchdog
  input  wire logic                  wd_fail_i,
  output logic                       wd_reset_o,
  output logic                       dev_mode_o,
  // Wake configuration
  input  wire logic [WK_SRC_W-1:0]   wake_source_control_i,
  input  wire logic [2:0]            periodic_timer_control_i,
  output logic [WK_SRC_W-1:0]        wake_src_active_o,
  output logic                       timer_irq_o,
  // Buck regulator
  input  wire logic                  pfm_to_pwm_auto_i,
  input  wire logic                  pfm_to_pwm_manual_i,
  input  wire logic                  vs_low_i,
  input  wire logic                  target_reached_i,
  input  wire logic [DUTY_W-1:0]     duty_loop_i,
  output logic                       reg_enable_o,
  output logic                       pwm_mode_o,
  output logic [DUTY_W-1:0]          duty_o,
  output logic                       soft_start_o,
  // Regulator status
  input  wire logic                  sw_open_i,
  input  wire logic                  sw_short_i,
  input  wire logic                  out_window_i,
  output logic [2:0]                 regulator_status_o
);

  // ==========================================================================
  // Functions
  // ==========================================================================
  function automatic logic [TMR_W-1:0] period_cycles(input logic [2:0] code);
    int unsigned ms;
    ms = PER_MS_6;
    unique case (code) // [R23]
      3'h0: ms = PER_MS_0;
      3'h1: ms = PER_MS_1;
      3'h2: ms = PER_MS_2;
      3'h3: ms = PER_MS_3;
      3'h4: ms = PER_MS_4;
      3'h5: ms = PER_MS_5;
      3'h6: ms = PER_MS_6;
      3'h7: ms = PER_MS_6;
    endcase
    return TMR_W'(ms * MS_CYCLES - 1); // [R13]
  endfunction

  // ==========================================================================
  // Pin synchroniser
  // ==========================================================================
  logic strap_s1_reg, strap_s2_reg;
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      strap_s1_reg <= 1'b1;
      strap_s2_reg <= 1'b1;
    end else if (ce_i) begin
      strap_s1_reg <= test_strap_pin_i;
      strap_s2_reg <= strap_s1_reg;
    end
  end

  // ==========================================================================
  // Mode decode
  // ==========================================================================
  wire in_init    = (mode_i == SDWRC_MODE_INIT);
  wire in_normal  = (mode_i == SDWRC_MODE_NORMAL);
  wire in_stop    = (mode_i == SDWRC_MODE_STOP);
  wire in_sleep   = (mode_i == SDWRC_MODE_SLEEP);
  wire in_restart = (mode_i == SDWRC_MODE_RESTART);
  wire in_fs      = (mode_i == SDWRC_MODE_FAILSAFE);

  // ==========================================================================
  // Development mode latch
  // ==========================================================================
  logic dev_reg, swr_lock_reg;
  wire dev_enter = in_init && !strap_s2_reg && spi_cmd_i && !sw_reset_i && !swr_lock_reg; // [R1] [R3] [R6]
  wire dev_leave = sw_reset_i || (power_down_i && strap_s2_reg); // [R4]

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      dev_reg      <= 1'b0; // [R2]
      swr_lock_reg <= 1'b0;
    end else if (ce_i) begin
      if (sw_reset_i) begin
        swr_lock_reg <= 1'b1; // [R3]
      end
      if (dev_leave) begin
        dev_reg <= 1'b0; // [R4]
      end else if (dev_enter) begin
        dev_reg <= 1'b1; // [R1]
      end
    end
  end

  assign dev_mode_o        = dev_reg;
  assign strap_pullup_en_o = in_init; // [R7]
  assign wd_reset_o        = wd_fail_i && !dev_reg; // [R5]

  // ==========================================================================
  // Wake sources
  // ==========================================================================
  assign wake_src_active_o = in_fs ? WK_DEFAULT : wake_source_control_i; // [R9]

  // ==========================================================================
  // Periodic timer
  // ==========================================================================
  logic [TMR_W-1:0] tmr_reg;
  logic             irq_reg;
  wire tmr_en   = wake_source_control_i[WK_TIMER_BIT] && (in_normal || in_stop); // [R10]
  wire tmr_done = tmr_en && (tmr_reg >= period_cycles(periodic_timer_control_i));

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      tmr_reg <= '0;
      irq_reg <= 1'b0;
    end else if (ce_i) begin
      irq_reg <= tmr_done; // [R12]
      if (!tmr_en || tmr_done) begin
        tmr_reg <= '0; // [R12]
      end else begin
        tmr_reg <= tmr_reg + TMR_W'(1);
      end
    end
  end

  assign timer_irq_o = irq_reg;

  // ==========================================================================
  // Regulator enable, modulation and soft start
  // ==========================================================================
  sdwrc_mode_type mode_prev_reg;
  logic           por_reg;
  logic           stop_pwm_reg;
  logic [7:0]     sw_cnt_reg;

  wire reg_en      = in_normal || in_stop || in_restart; // [R14]
  wire stop_entry  = in_stop && (mode_prev_reg != SDWRC_MODE_STOP); // [R16]
  wire ss_start    = por_reg
                  || (in_restart && (mode_prev_reg == SDWRC_MODE_SLEEP))
                  || (in_restart && (mode_prev_reg == SDWRC_MODE_FAILSAFE)); // [R18]
  wire sw_tick     = (sw_cnt_reg == 8'(SW_PERIOD - 1));

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      mode_prev_reg <= SDWRC_MODE_INIT;
      por_reg       <= 1'b1;
      stop_pwm_reg  <= 1'b0;
      sw_cnt_reg    <= 8'h00;
    end else if (ce_i) begin
      mode_prev_reg <= mode_i;
      if (reg_en) begin
        por_reg <= 1'b0;
      end
      sw_cnt_reg <= sw_tick ? 8'h00 : sw_cnt_reg + 8'h01;
      if (!in_stop || stop_entry) begin
        stop_pwm_reg <= 1'b0; // [R16]
      end else if (pfm_to_pwm_auto_i || pfm_to_pwm_manual_i) begin
        stop_pwm_reg <= 1'b1; // [R15]
      end
    end
  end

  logic [DUTY_W-1:0] ss_duty;
  logic              ss_ramping;
  logic              ss_regulating;

  sdwrc_ramp #(
    .HOLD_PERIODS (SS_HOLD),
    .DUTY_STEP    (SS_STEP[7:0])
  ) u_ramp ( // [R24]
    .mclk_i           (mclk_i),
    .rst_i            (rst_i),
    .ce_i             (ce_i),
    .start_i          (ss_start),
    .enable_i         (reg_en),
    .period_tick_i    (sw_tick),
    .target_reached_i (target_reached_i),
    .duty_o           (ss_duty),
    .ramping_o        (ss_ramping),
    .regulating_o     (ss_regulating)
  );

  wire pwm_sel = reg_en && (in_normal || in_restart || stop_pwm_reg); // [R15]
  wire [DUTY_W-1:0] duty_sel = !reg_en     ? 8'h00 :
                               ss_start    ? DUTY_MIN : // [R19]
                               ss_ramping  ? ss_duty :
                               vs_low_i    ? DUTY_FULL : // [R17]
                               duty_loop_i;

  logic [DUTY_W-1:0] duty_reg;
  logic              pwm_reg;
  logic [2:0]        stat_reg;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      duty_reg <= 8'h00;
      pwm_reg  <= 1'b0;
      stat_reg <= 3'h0;
    end else if (ce_i) begin
      duty_reg <= duty_sel;
      pwm_reg  <= pwm_sel;
      stat_reg <= {out_window_i, sw_short_i, sw_open_i}; // [R20] [R21]
    end
  end

  assign reg_enable_o       = reg_en;
  assign pwm_mode_o         = pwm_reg;
  assign duty_o             = duty_reg;
  assign soft_start_o       = ss_ramping && !ss_regulating;
  assign regulator_status_o = stat_reg;

endmodule

// ### sdwrc_checker.sv
// Port-level assertions of the development-mode, wake and regulator block
`timescale 1ns/100ps
module sdwrc_checker
  import sdwrc_pkg::*;
(
  // Clock and reset
  input wire logic                mclk_i,
  input wire logic                rst_i,
  input wire logic                ce_i,
  // Inputs watched
  input wire sdwrc_mode_type      mode_i,
  input wire logic                spi_cmd_i,
  input wire logic                sw_reset_i,
  input wire logic                test_strap_pin_i,
  input wire logic                wd_fail_i,
  input wire logic [WK_SRC_W-1:0] wake_source_control_i,
  input wire logic                pfm_to_pwm_auto_i,
  input wire logic                pfm_to_pwm_manual_i,
  // Outputs watched
  input wire logic                strap_pullup_en_o,
  input wire logic                wd_reset_o,
  input wire logic                dev_mode_o,
  input wire logic [WK_SRC_W-1:0] wake_src_active_o,
  input wire logic                timer_irq_o,
  input wire logic                reg_enable_o,
  input wire logic                pwm_mode_o
);
  // ==========================================================================
  // Helper logic
  // ==========================================================================
  logic sw_seen_reg;
  logic sw_seen_next;
  logic run_mode;
  assign sw_seen_next = sw_seen_reg | (ce_i & sw_reset_i);
  assign run_mode     = (mode_i == SDWRC_MODE_NORMAL) || (mode_i == SDWRC_MODE_STOP);
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sw_seen_reg <= 1'b0;
    end else begin
      sw_seen_reg <= sw_seen_next;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  // ==========================================================================
  // Sequences and assertions
  // ==========================================================================
  sequence seq_strap_low;
    (ce_i && !test_strap_pin_i && !sw_seen_reg)[*4];
  endsequence
  sequence seq_init_cmd;
    ce_i && (mode_i == SDWRC_MODE_INIT) && spi_cmd_i && !sw_reset_i;
  endsequence

  a_pullup_init_only: assert property (strap_pullup_en_o == (mode_i == SDWRC_MODE_INIT))
    else $error("strap pull-up enable wrong for mode");
  a_wd_dev_mask: assert property (wd_reset_o == (wd_fail_i && !dev_mode_o))
    else $error("watchdog reset wrong for development state");
  a_wake_fail_default: assert property (wake_src_active_o ==
      ((mode_i == SDWRC_MODE_FAILSAFE) ? WK_DEFAULT : wake_source_control_i))
    else $error("active wake sources wrong");
  a_reg_mode_enable: assert property (reg_enable_o == (run_mode || mode_i == SDWRC_MODE_RESTART))
    else $error("regulator enable wrong for mode");
  a_dev_entry_cmd: assert property (seq_strap_low ##0 seq_init_cmd |=> dev_mode_o)
    else $error("development mode not entered");
  a_dev_entry_lock: assert property (sw_seen_reg && !dev_mode_o |=> !dev_mode_o)
    else $error("development mode entered after software reset");
  a_dev_swr_exit: assert property (ce_i && sw_reset_i |=> !dev_mode_o)
    else $error("development mode kept after software reset");
  a_irq_single_pulse: assert property (timer_irq_o |=> !timer_irq_o)
    else $error("timer interrupt longer than one cycle");
  a_irq_idle_quiet: assert property ((!wake_source_control_i[WK_TIMER_BIT] || !run_mode)[*3] |-> !timer_irq_o)
    else $error("timer interrupt while disabled");
  a_pfm_stop_entry: assert property ($past(mode_i) != SDWRC_MODE_STOP && mode_i == SDWRC_MODE_STOP && ce_i
      && !pfm_to_pwm_auto_i && !pfm_to_pwm_manual_i |=> !pwm_mode_o)
    else $error("buck not in PFM after stop entry");
endmodule

bind sdwrc_ctrl sdwrc_checker chk (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i), .mode_i(mode_i),
  .spi_cmd_i(spi_cmd_i), .sw_reset_i(sw_reset_i), .test_strap_pin_i(test_strap_pin_i), .wd_fail_i(wd_fail_i),
  .wake_source_control_i(wake_source_control_i), .pfm_to_pwm_auto_i(pfm_to_pwm_auto_i),
  .pfm_to_pwm_manual_i(pfm_to_pwm_manual_i), .strap_pullup_en_o(strap_pullup_en_o), .wd_reset_o(wd_reset_o),
  .dev_mode_o(dev_mode_o), .wake_src_active_o(wake_src_active_o), .timer_irq_o(timer_irq_o),
  .reg_enable_o(reg_enable_o), .pwm_mode_o(pwm_mode_o));

// ### sdwrc_host.sv
// Host controller and strap pin model at the far side of the block
`timescale 1ns/100ps
module sdwrc_host
  import sdwrc_pkg::*;
(
  // Clock and pull-up from the device
  input  wire logic                mclk_i,
  input  wire logic                pullup_en_i,
  // Host commands and pin
  output logic                     spi_cmd_o,
  output logic                     sw_reset_o,
  output wire logic                strap_o,
  output logic [WK_SRC_W-1:0]      wake_ctrl_o,
  output logic [2:0]               timer_ctrl_o
);
  logic [1:0] strap_drv;
  logic       strap_last;
  initial begin
    spi_cmd_o    = 1'b0;
    sw_reset_o   = 1'b0;
    wake_ctrl_o  = 4'h0;
    timer_ctrl_o = 3'h0;
    strap_drv    = 2'h0;
    strap_last   = 1'b1;
  end
  // Released pin without pull-up floats, shown as inverse of last level
  always @(negedge mclk_i) strap_last <= strap_o;
  assign strap_o = (strap_drv == 2'h1) ? 1'b0 : ((strap_drv == 2'h2) || pullup_en_i) ? 1'b1 : ~strap_last;

  task automatic set_strap(input logic [1:0] d);
    @(negedge mclk_i) strap_drv = d;
  endtask
  task automatic send_cmd();
    @(negedge mclk_i) spi_cmd_o = 1'b1;
    @(negedge mclk_i) spi_cmd_o = 1'b0;
  endtask
  task automatic soft_reset();
    @(negedge mclk_i) sw_reset_o = 1'b1;
    @(negedge mclk_i) sw_reset_o = 1'b0;
  endtask
  // Period first, wake enables afterwards
  task automatic cfg(input logic [2:0] code, input logic [WK_SRC_W-1:0] wk);
    @(negedge mclk_i) timer_ctrl_o = code;
    @(negedge mclk_i) wake_ctrl_o = wk;
  endtask
endmodule

// ### tb_top.sv
// Self-checking testbench of the development-mode, wake and regulator block
`timescale 1ns/100ps
module tb_top
  import sdwrc_pkg::*;
;
  typedef struct packed {
    sdwrc_mode_type m; logic wd; logic [3:0] wk; logic pu; logic wr; logic [3:0] act; logic re;
  } sdwrc_row_type;
  logic mclk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, spi_cmd_i, sw_reset_i, power_down_i = 1'b0;
  logic test_strap_pin_i, strap_pullup_en_o, wd_fail_i = 1'b0, wd_reset_o, dev_mode_o, timer_irq_o;
  logic pfm_to_pwm_auto_i = 1'b0, pfm_to_pwm_manual_i = 1'b0, vs_low_i = 1'b0, target_reached_i = 1'b0;
  logic reg_enable_o, pwm_mode_o, soft_start_o, sw_open_i = 1'b0, sw_short_i = 1'b0, out_window_i = 1'b0;
  logic [3:0] wake_source_control_i, wake_src_active_o;
  logic [2:0] periodic_timer_control_i, regulator_status_o;
  logic [7:0] duty_loop_i = 8'h5a, duty_o;
  sdwrc_mode_type mode_i = SDWRC_MODE_INIT;
  sdwrc_row_type rows[6];
  int err_total = 0, comparisons = 0, n;
  int pms[8] = '{PER_MS_0, PER_MS_1, PER_MS_2, PER_MS_3, PER_MS_4, PER_MS_5, PER_MS_6, PER_MS_6};

  always #20 mclk_i = ~mclk_i;

  sdwrc_ctrl #(.SS_HOLD(2), .SS_STEP(8), .MS_CYCLES(2), .SW_PERIOD(2)) uut (.mclk_i(mclk_i), .rst_i(rst_i),
    .ce_i(ce_i), .mode_i(mode_i), .spi_cmd_i(spi_cmd_i), .sw_reset_i(sw_reset_i), .power_down_i(power_down_i),
    .test_strap_pin_i(test_strap_pin_i), .strap_pullup_en_o(strap_pullup_en_o), .wd_fail_i(wd_fail_i),
    .wd_reset_o(wd_reset_o), .dev_mode_o(dev_mode_o), .wake_source_control_i(wake_source_control_i),
    .periodic_timer_control_i(periodic_timer_control_i), .wake_src_active_o(wake_src_active_o),
    .timer_irq_o(timer_irq_o), .pfm_to_pwm_auto_i(pfm_to_pwm_auto_i), .pfm_to_pwm_manual_i(pfm_to_pwm_manual_i),
    .vs_low_i(vs_low_i), .target_reached_i(target_reached_i), .duty_loop_i(duty_loop_i),
    .reg_enable_o(reg_enable_o), .pwm_mode_o(pwm_mode_o), .duty_o(duty_o), .soft_start_o(soft_start_o),
    .sw_open_i(sw_open_i), .sw_short_i(sw_short_i), .out_window_i(out_window_i),
    .regulator_status_o(regulator_status_o));
  sdwrc_host host (.mclk_i(mclk_i), .pullup_en_i(strap_pullup_en_o), .spi_cmd_o(spi_cmd_i),
    .sw_reset_o(sw_reset_i), .strap_o(test_strap_pin_i), .wake_ctrl_o(wake_source_control_i),
    .timer_ctrl_o(periodic_timer_control_i));

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic do_reset();
    @(negedge mclk_i) rst_i = 1'b1;
    repeat (12) @(negedge mclk_i);
    rst_i = 1'b0;
  endtask
  task automatic ticks(input int k);
    repeat (k) @(negedge mclk_i);
  endtask
  task automatic set_mode(input sdwrc_mode_type m);
    @(negedge mclk_i) mode_i = m;
    ticks(3);
  endtask
  task automatic wait_irq();
    n = 0;
    do begin
      @(negedge mclk_i);
      n++;
    end while (timer_irq_o !== 1'b1 && n < 9000);
  endtask
  task automatic conclude();
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ==========================================================================
  // Watchdog
  // ==========================================================================
  initial begin
    repeat (60000) @(posedge mclk_i);
    err_total++;
    conclude();
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    rows = '{'{SDWRC_MODE_INIT, 1'b1, 4'h3, 1'b1, 1'b1, 4'h3, 1'b0},
             '{SDWRC_MODE_NORMAL, 1'b1, 4'h4, 1'b0, 1'b1, 4'h4, 1'b1},
             '{SDWRC_MODE_STOP, 1'b0, 4'ha, 1'b0, 1'b0, 4'ha, 1'b1},
             '{SDWRC_MODE_SLEEP, 1'b1, 4'h0, 1'b0, 1'b1, 4'h0, 1'b0},
             '{SDWRC_MODE_RESTART, 1'b0, 4'hf, 1'b0, 1'b0, 4'hf, 1'b1},
             '{SDWRC_MODE_FAILSAFE, 1'b1, 4'h1, 1'b0, 1'b1, 4'he, 1'b0}};
    do_reset();
    chk(dev_mode_o, 1'b0);
    host.send_cmd();
    ticks(2);
    chk(dev_mode_o, 1'b0);
    host.set_strap(2'h1);
    ticks(4);
    host.send_cmd();
    ticks(2);
    chk(dev_mode_o, 1'b1);
    wd_fail_i = 1'b1;
    ticks(1);
    chk(wd_reset_o, 1'b0);
    @(negedge mclk_i) power_down_i = 1'b1;
    @(negedge mclk_i) power_down_i = 1'b0;
    chk(dev_mode_o, 1'b1);
    host.set_strap(2'h2);
    ticks(4);
    @(negedge mclk_i) power_down_i = 1'b1;
    @(negedge mclk_i) power_down_i = 1'b0;
    chk({dev_mode_o, wd_reset_o}, 2'h1);
    host.set_strap(2'h1);
    ticks(4);
    host.send_cmd();
    chk(dev_mode_o, 1'b1);
    host.soft_reset();
    ticks(1);
    chk(dev_mode_o, 1'b0);
    host.send_cmd();
    ticks(2);
    chk(dev_mode_o, 1'b0);
    wd_fail_i = 1'b0;
    do_reset();
    set_mode(SDWRC_MODE_NORMAL);
    chk({soft_start_o, duty_o}, {1'b1, DUTY_MIN});
    n = 0;
    while (duty_o === DUTY_MIN && n < 60) begin
      ticks(1);
      n++;
    end
    chk(duty_o, DUTY_MIN + 8'h08);
    target_reached_i = 1'b1;
    duty_loop_i = 8'h3c;
    ticks(3);
    chk({soft_start_o, pwm_mode_o, duty_o}, {2'h1, 8'h3c});
    vs_low_i = 1'b1;
    ticks(3);
    chk(duty_o, DUTY_FULL);
    vs_low_i = 1'b0;
    target_reached_i = 1'b0;
    host.cfg(3'h0, 4'h0);
    set_mode(SDWRC_MODE_SLEEP);
    set_mode(SDWRC_MODE_RESTART);
    chk({soft_start_o, duty_o}, {1'b1, DUTY_MIN});
    target_reached_i = 1'b1;
    for (int k = 0; k < 2; k++) begin
      set_mode(SDWRC_MODE_NORMAL);
      set_mode(SDWRC_MODE_STOP);
      chk(pwm_mode_o, 1'b0);
      @(negedge mclk_i) {pfm_to_pwm_manual_i, pfm_to_pwm_auto_i} = (k == 0) ? 2'h1 : 2'h2;
      @(negedge mclk_i) {pfm_to_pwm_manual_i, pfm_to_pwm_auto_i} = 2'h0;
      ticks(2);
      chk(pwm_mode_o, 1'b1);
    end
    set_mode(SDWRC_MODE_NORMAL);
    for (int k = 0; k < 8; k++) begin
      @(negedge mclk_i) {out_window_i, sw_short_i, sw_open_i} = k[2:0];
      ticks(2);
      chk(regulator_status_o, k[2:0]);
      chk({reg_enable_o, pwm_mode_o, dev_mode_o}, 3'h6);
    end
    @(negedge mclk_i) ce_i = 1'b0;
    sw_open_i = 1'b0;
    ticks(2);
    chk(regulator_status_o, 3'h7);
    ce_i = 1'b1;
    ticks(2);
    chk(regulator_status_o, 3'h6);
    foreach (rows[i]) begin
      host.cfg(3'h0, rows[i].wk);
      @(negedge mclk_i) {mode_i, wd_fail_i} = {rows[i].m, rows[i].wd};
      ticks(1);
      chk({strap_pullup_en_o, wd_reset_o, wake_src_active_o, reg_enable_o},
          {rows[i].pu, rows[i].wr, rows[i].act, rows[i].re});
    end
    set_mode(SDWRC_MODE_NORMAL);
    for (int c = 0; c < 8; c++) begin
      host.cfg(c[2:0], 4'h0);
      host.cfg(c[2:0], 4'h1);
      wait_irq();
      wait_irq();
      chk(n, pms[c] * 2);
    end
    conclude();
  end
endmodule
